// >>> core/ubc_cfg.svh
// constants for the descriptor table, configuration and endpoint control block
// Summary of operation
// - second table page register keeps base address bits 23:16 in bits 7:0
// - third table page register keeps base address bits 31:24 in bits 7:0
// - table base address is 512-byte aligned; low nine bits read zero; here bits 15:9 have no register and read zero too
// - bits 31:8 of every register read zero and ignore writes
// - configuration bit 7 enables eye-pattern test; resets to zero
// - configuration bit 6 makes output-enable monitor follow line driving
// - configuration bit 4 halts the module while the device is idle
// - configuration bit 0 suspends on sleep; else software sets suspend
// - endpoint 0 bit 7 allows direct low-speed connection in host mode
// - endpoint 0 bit 6 clear lets hardware retry NAKed transactions
// - bit 4 rejects SETUP only when transmit and receive both enabled
// - endpoint bit 3 enables reception
// - endpoint bit 2 enables transmission
// - endpoint bit 1 reports that the endpoint was stalled
// - endpoint bit 0 enables handshakes; clear suits isochronous
// - sixteen endpoint control registers, all bits reset to zero
`ifndef UBC_CFG_SVH
`define UBC_CFG_SVH
`define UBC_ADDR_W        8
`define UBC_OFS_BDT_MID   8'h00
`define UBC_OFS_BDT_TOP   8'h04
`define UBC_OFS_CFG       8'h08
`define UBC_OFS_IRQ_STAT  8'h0C
`define UBC_OFS_IRQ_MASK  8'h10
`define UBC_OFS_EP_BASE   8'h40
`define UBC_OFS_EP_LAST   8'h7C
`define UBC_CFG_MASK      8'hD1
`define UBC_EP0_MASK      8'hDF
`define UBC_EPN_MASK      8'h1F
`define UBC_RST_VAL       8'h00
`define UBC_BDT_ALIGN     9
`define UBC_B_EYE         7
`define UBC_B_OEMON       6
`define UBC_B_SIDL        4
`define UBC_B_ASUSP       0
`define UBC_B_LOW_SPEED_DIRECT        7
`define UBC_B_NAK_RETRY_DISABLE    6
`define UBC_B_CONDIS      4
`define UBC_B_RXEN        3
`define UBC_B_TXEN        2
`define UBC_B_STALL       1
`define UBC_B_HSHK        0
`define UBC_N_EP          16
`endif

// >>> core/ubc_ep_mem.sv
// sixteen-entry endpoint control store with registered read port
`timescale 1ns/100ps
`default_nettype none
`include "ubc_cfg.svh"
module ubc_ep_mem (
  input  wire logic                clk,     // system clock
  input  wire logic                rst_n,   // sync reset, active low
  input  wire logic                we,      // software write
  input  wire logic [3:0]          waddr,   // write endpoint
  input  wire ubc_pkg::ubc_byte_t  wdata,   // masked write data
  input  wire logic                set_stall, // hardware stall event
  input  wire logic [3:0]          saddr,   // stall endpoint
  input  wire logic [3:0]          raddr,   // read endpoint
  output ubc_pkg::ubc_byte_t       rdata,   // registered read data
  output logic [8*`UBC_N_EP-1:0]   flat     // all entries for live use
);
  import ubc_pkg::*;
  ubc_byte_t mem_q [`UBC_N_EP];

  // one flop row per endpoint; stall set wins over software write
  genvar gi;
  generate
    for (gi = 0; gi < `UBC_N_EP; gi++) begin : g_ep
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem_q[gi] <= `UBC_RST_VAL;
        end else begin
          if (we && waddr == 4'(gi)) begin
            mem_q[gi] <= wdata;
          end
          if (set_stall && saddr == 4'(gi)) begin
            mem_q[gi][`UBC_B_STALL] <= 1'b1;
          end
        end
      end
      assign flat[8*gi +: 8] = mem_q[gi];
    end
  endgenerate

  // read data come from a register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= `UBC_RST_VAL;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

// >>> core/ubc_pkg.sv
// types shared by the endpoint control block
package ubc_pkg;
  typedef logic [7:0] ubc_byte_t;
  typedef struct packed {
    logic [3:0] ep;
    logic       stall;
  } ubc_evt_s;
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic setup_ok;
    logic hshk_en;
  } ubc_ep_s;
endpackage

// >>> core/ubc_top.sv
// descriptor table base, module configuration and endpoint control registers
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ubc_cfg.svh"
module ubc_top (
  input  wire logic                     clk,          // system clock 50 MHz
  input  wire logic                     rst_n,        // sync reset, active low
  input  wire logic [`UBC_ADDR_W-1:0]   addr,         // register byte address
  input  wire logic [31:0]              wdata,        // write data
  input  wire logic                     wr,           // write strobe
  input  wire logic                     rd,           // read strobe
  output logic [31:0]                   rdata,        // read data, cycle after rd
  input  wire logic                     host_mode,    // core is acting as host
  input  wire logic                     cpu_idle,     // device in idle mode
  input  wire logic                     cpu_sleep,    // device in sleep mode
  input  wire logic                     manual_suspend, // power-control suspend bit
  input  wire logic                     line_drive,   // transceiver drives D+/D-
  input  wire ubc_pkg::ubc_evt_s        evt,          // stall handshake sent
  input  wire logic [3:0]               tok_ep,       // endpoint of current token
  output logic [31:0]                   bdt_base,     // table base address
  output logic                          eye_pattern_test_enable, // eye test on
  output logic                          output_enable_monitor,   // oe monitor pin
  output logic                          module_halt,  // halt for idle
  output logic                          module_suspend, // suspend incl 48 MHz clock
  output logic                          low_speed_direct,  // host direct low speed
  output logic                          nak_auto_retry,    // hardware retries NAK
  output ubc_pkg::ubc_ep_s              tok_ctl,      // controls for tok_ep
  output logic                          irq           // level interrupt
);
  import ubc_pkg::*;

  ubc_byte_t table_base_mid_bits_q;
  ubc_byte_t table_base_top_bits_q;
  ubc_byte_t cfg_q;
  logic      stat_q;
  logic      mask_q;
  logic      rd_q;
  logic      rd_ep_q;
  logic      rd_hit_q;
  ubc_byte_t rd_reg_q;
  ubc_byte_t ep_rdata;
  logic [8*`UBC_N_EP-1:0] ep_flat;
  logic      line_s1_q;
  logic      line_s2_q;
  logic      ep_we;
  ubc_byte_t ep_wmask;
  ubc_byte_t tok_byte;

  // endpoint decode, used for write and read alike
  function automatic logic is_ep(input logic [`UBC_ADDR_W-1:0] a);
    return (a >= `UBC_OFS_EP_BASE) && (a <= `UBC_OFS_EP_LAST) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [3:0] ep_idx(input logic [`UBC_ADDR_W-1:0] a);
    return a[5:2];
  endfunction

  // host-only bits live in endpoint 0; bit 5 never stores
  assign ep_wmask = (ep_idx(addr) == 4'h0) ? `UBC_EP0_MASK : `UBC_EPN_MASK;
  assign ep_we    = wr && is_ep(addr);

  ubc_ep_mem u_mem (
    .clk       (clk),
    .rst_n     (rst_n),
    .we        (ep_we),
    .waddr     (ep_idx(addr)),
    .wdata     (wdata[7:0] & ep_wmask),
    .set_stall (evt.stall),
    .saddr     (evt.ep),
    .raddr     (ep_idx(addr)),
    .rdata     (ep_rdata),
    .flat      (ep_flat)
  );

  // mid byte of the table base
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      table_base_mid_bits_q <= `UBC_RST_VAL;
    end else if (wr && addr == `UBC_OFS_BDT_MID) begin
      table_base_mid_bits_q <= wdata[7:0];
    end
  end

  // top byte of the table base
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      table_base_top_bits_q <= `UBC_RST_VAL;
    end else if (wr && addr == `UBC_OFS_BDT_TOP) begin
      table_base_top_bits_q <= wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= `UBC_RST_VAL;
    end else if (wr && addr == `UBC_OFS_CFG) begin
      cfg_q <= wdata[7:0] & `UBC_CFG_MASK;
    end
  end

  // stall event status; a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 1'b0;
    end else if (evt.stall) begin
      stat_q <= 1'b1;
    end else if (wr && addr == `UBC_OFS_IRQ_STAT && wdata[0]) begin
      stat_q <= 1'b0;
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= 1'b0;
    end else if (wr && addr == `UBC_OFS_IRQ_MASK) begin
      mask_q <= wdata[0];
    end
  end

  // interrupt from flops; one cycle behind the status bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= stat_q && mask_q;
    end
  end

  // register-side read capture; endpoint data come from the memory flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q     <= 1'b0;
      rd_ep_q  <= 1'b0;
      rd_hit_q <= 1'b0;
      rd_reg_q <= `UBC_RST_VAL;
    end else begin
      rd_q     <= rd;
      rd_ep_q  <= is_ep(addr);
      rd_hit_q <= 1'b1;
      case (addr)
        `UBC_OFS_BDT_MID:  rd_reg_q <= table_base_mid_bits_q;
        `UBC_OFS_BDT_TOP:  rd_reg_q <= table_base_top_bits_q;
        `UBC_OFS_CFG:      rd_reg_q <= cfg_q;
        `UBC_OFS_IRQ_STAT: rd_reg_q <= {7'h00, stat_q};
        `UBC_OFS_IRQ_MASK: rd_reg_q <= {7'h00, mask_q};
        default: begin
          rd_reg_q <= `UBC_RST_VAL;
          rd_hit_q <= 1'b0;
        end
      endcase
    end
  end

  // upper bits read zero; unmapped reads zero too
  always_comb begin
    rdata = 32'h0000_0000;
    if (rd_q && rd_ep_q) begin
      rdata[7:0] = ep_rdata;
    end else if (rd_q && rd_hit_q) begin
      rdata[7:0] = rd_reg_q;
    end
  end

  // low sixteen address bits forced to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bdt_base <= 32'h0000_0000;
    end else begin
      bdt_base <= {table_base_top_bits_q, table_base_mid_bits_q, 16'h0000};
    end
  end

  // line-drive pin enters through two flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_s1_q <= 1'b0;
      line_s2_q <= 1'b0;
    end else begin
      line_s1_q <= line_drive;
      line_s2_q <= line_s1_q;
    end
  end

  // power and test outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eye_pattern_test_enable <= 1'b0;
      output_enable_monitor   <= 1'b0;
      module_halt             <= 1'b0;
      module_suspend          <= 1'b0;
    end else begin
      eye_pattern_test_enable <= cfg_q[`UBC_B_EYE];
      // monitor follows driving only when enabled
      output_enable_monitor   <= cfg_q[`UBC_B_OEMON] && line_s2_q;
      module_halt             <= cfg_q[`UBC_B_SIDL] && cpu_idle;
      module_suspend          <= (cfg_q[`UBC_B_ASUSP] && cpu_sleep) || manual_suspend;
    end
  end

  assign tok_byte = ep_flat[8*tok_ep +: 8];

  // per-token endpoint controls and host options
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_speed_direct <= 1'b0;
      nak_auto_retry   <= 1'b0;
      tok_ctl          <= '0;
    end else begin
      // endpoint 0 low speed, host only
      low_speed_direct <= host_mode && ep_flat[`UBC_B_LOW_SPEED_DIRECT];
      nak_auto_retry   <= host_mode && !ep_flat[`UBC_B_NAK_RETRY_DISABLE];
      tok_ctl.rx_en    <= tok_byte[`UBC_B_RXEN];
      tok_ctl.tx_en    <= tok_byte[`UBC_B_TXEN];
      tok_ctl.setup_ok <= !(tok_byte[`UBC_B_RXEN] && tok_byte[`UBC_B_TXEN]
                            && tok_byte[`UBC_B_CONDIS]);
      tok_ctl.hshk_en  <= tok_byte[`UBC_B_HSHK];
    end
  end

  // checks
  // stall seen in bit 1
  property p_stall_sets;
    @(posedge clk) disable iff (!rst_n)
      evt.stall |=> ep_flat[8*$past(evt.ep) + `UBC_B_STALL];
  endproperty
  a_stall_sets: assert property (p_stall_sets) else $error("stall bit not set");

  property p_eye;
    @(posedge clk) disable iff (!rst_n)
      (wr && addr == `UBC_OFS_CFG) |=> ##1 (eye_pattern_test_enable == $past(wdata[7], 2));
  endproperty
  a_eye: assert property (p_eye) else $error("eye test not following config");

  property p_oemon;
    @(posedge clk) disable iff (!rst_n)
      !cfg_q[`UBC_B_OEMON] |=> !output_enable_monitor;
  endproperty
  a_oemon: assert property (p_oemon) else $error("oe monitor active while off");

  property p_halt;
    @(posedge clk) disable iff (!rst_n)
      (cfg_q[`UBC_B_SIDL] && cpu_idle) |=> module_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt in idle");

  property p_susp;
    @(posedge clk) disable iff (!rst_n)
      (cfg_q[`UBC_B_ASUSP] && cpu_sleep) |=> module_suspend;
  endproperty
  a_susp: assert property (p_susp) else $error("no auto suspend");

  property p_upper_zero;
    @(posedge clk) disable iff (!rst_n)
      rdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");

  property p_mid_rd;
    @(posedge clk) disable iff (!rst_n)
      (wr && addr == `UBC_OFS_BDT_MID) ##1 (rd && addr == `UBC_OFS_BDT_MID)
        |=> rdata[7:0] == $past(wdata[7:0], 2);
  endproperty
  a_mid_rd: assert property (p_mid_rd) else $error("mid byte readback wrong");

  property p_align;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> (bdt_base[`UBC_BDT_ALIGN-1:0] == 9'h000)
               && (bdt_base[31:24] == $past(table_base_top_bits_q));
  endproperty
  a_align: assert property (p_align) else $error("base misaligned or stale");

  property p_setup;
    @(posedge clk) disable iff (!rst_n)
      (tok_byte[`UBC_B_CONDIS] && !tok_byte[`UBC_B_RXEN]) |=> tok_ctl.setup_ok;
  endproperty
  a_setup: assert property (p_setup) else $error("condis not ignored");

  property p_top_rd;
    @(posedge clk) disable iff (!rst_n)
      (wr && addr == `UBC_OFS_BDT_TOP) ##1 (rd && addr == `UBC_OFS_BDT_TOP)
        |=> rdata[7:0] == $past(wdata[7:0], 2);
  endproperty
  a_top_rd: assert property (p_top_rd) else $error("top byte readback wrong");

  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
      !rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  property p_oemon_on;
    @(posedge clk) disable iff (!rst_n)
      (cfg_q[`UBC_B_OEMON] && line_s2_q) |=> output_enable_monitor;
  endproperty
  a_oemon_on: assert property (p_oemon_on) else $error("oe monitor idle");

  property p_lsd_host;
    @(posedge clk) disable iff (!rst_n)
      !host_mode |=> !low_speed_direct;
  endproperty
  a_lsd_host: assert property (p_lsd_host) else $error("low speed outside host");

  property p_retry;
    @(posedge clk) disable iff (!rst_n)
      (host_mode && !ep_flat[`UBC_B_NAK_RETRY_DISABLE]) |=> nak_auto_retry;
  endproperty
  a_retry: assert property (p_retry) else $error("nak retry missing");

  property p_rx;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> tok_ctl.rx_en == $past(ep_flat[8*tok_ep + `UBC_B_RXEN]);
  endproperty
  a_rx: assert property (p_rx) else $error("receive enable wrong");

  property p_tx;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> tok_ctl.tx_en == $past(ep_flat[8*tok_ep + `UBC_B_TXEN]);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit enable wrong");

  property p_hshk;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> tok_ctl.hshk_en == $past(ep_flat[8*tok_ep + `UBC_B_HSHK]);
  endproperty
  a_hshk: assert property (p_hshk) else $error("handshake enable wrong");

  property p_stall_hold;
    @(posedge clk) disable iff (!rst_n)
      (ep_flat[8*tok_ep + `UBC_B_STALL] && !(ep_we && ep_idx(addr) == tok_ep))
        |=> ep_flat[8*$past(tok_ep) + `UBC_B_STALL];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall bit lost");
endmodule
`default_nettype wire

// >>> tb/ubc_peer.sv
// far-side model: token endpoint, line driving and stall handshakes
`timescale 1ns/100ps
`default_nettype none
module ubc_peer (
  input  wire logic          clk,        // system clock
  output ubc_pkg::ubc_evt_s  evt,        // stall handshake pulse
  output logic [3:0]         tok_ep,     // endpoint of current token
  output logic               line_drive  // transceiver driving D+/D-
);
  import ubc_pkg::*;
  // quiet bus after power-up
  initial begin
    evt        = '0;
    tok_ep     = 4'h0;
    line_drive = 1'b0;
  end
  task automatic stall(input logic [3:0] e);
    @(posedge clk);
    evt <= '{ep: e, stall: 1'b1};
    @(posedge clk);
    // endpoint garbled outside the pulse so a stale field cannot match
    evt <= '{ep: ~e, stall: 1'b0};
  endtask
  // token and line level change just after an edge
  task automatic token(input logic [3:0] e);
    @(posedge clk);
    tok_ep <= e;
  endtask
  task automatic drive(input logic d);
    @(posedge clk);
    line_drive <= d;
  endtask
endmodule
`default_nettype wire

// >>> tb/usb_bdt_config_endpoint_ctrl_tb_top.sv
// self-checking bench for the table base, configuration and endpoint block
`timescale 1ns/100ps
`default_nettype none
`include "ubc_cfg.svh"
module usb_bdt_config_endpoint_ctrl_tb_top;
  import ubc_pkg::*;
  logic        clk       = 1'b0;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        host_mode;
  logic        cpu_idle;
  logic        cpu_sleep;
  logic        man_susp;
  logic [31:0] rdata;
  logic        line_drive;
  ubc_evt_s    evt;
  logic [3:0]  tok_ep;
  logic [31:0] bdt_base;
  logic        eye, oemon, halt, susp, lsd, retry, irq;
  ubc_ep_s     tok_ctl;
  int          err_total = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  logic [31:0] v;
  logic [7:0]  tw [5] = '{8'h0C, 8'h1D, 8'h18, 8'h14, 8'h01};
  logic [3:0]  te [5] = '{4'hE, 4'hD, 4'hA, 4'h6, 4'h3};

  ubc_peer u_peer (.clk(clk), .evt(evt), .tok_ep(tok_ep), .line_drive(line_drive));

  ubc_top u_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .host_mode(host_mode), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .manual_suspend(man_susp), .line_drive(line_drive), .evt(evt), .tok_ep(tok_ep),
    .bdt_base(bdt_base), .eye_pattern_test_enable(eye), .output_enable_monitor(oemon),
    .module_halt(halt), .module_suspend(susp), .low_speed_direct(lsd),
    .nak_auto_retry(retry), .tok_ctl(tok_ctl), .irq(irq));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 270 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total += 1;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask
  // one-cycle strobes; the gap edge keeps a strobe from being set twice at once
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // outputs are registered; the line input also crosses two sync flops
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] ep(input int n);
    return 8'(`UBC_OFS_EP_BASE + 4 * n);
  endfunction

  // main sequence
  initial begin
    // bus quiet and levels low while reset is held
    rst_n     <= 1'b0;
    addr      <= 8'h00;
    wdata     <= 32'h0;
    wr        <= 1'b0;
    rd        <= 1'b0;
    host_mode <= 1'b0;
    cpu_idle  <= 1'b0;
    cpu_sleep <= 1'b0;
    man_susp  <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`UBC_OFS_BDT_MID, 32'h0);
    rd_chk(`UBC_OFS_CFG, 32'h0);
    for (int n = 0; n < 16; n++) begin
      rd_chk(ep(n), 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
    // unmapped places read zero and ignore writes
    wr_reg(8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h80, 32'h0);
    // table base bytes
    wr_reg(`UBC_OFS_BDT_MID, 32'hFFFF_FFA5);
    wr_reg(`UBC_OFS_BDT_TOP, 32'h1234_56C3);
    rd_chk(`UBC_OFS_BDT_MID, 32'hA5);
    rd_chk(`UBC_OFS_BDT_TOP, 32'hC3);
    settle();
    chk(bdt_base, 32'hC3A5_0000);
    // back-to-back write then read, no idle cycle between strobes
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= `UBC_OFS_BDT_MID;
    wdata <= 32'h0000_005A;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    wr    <= 1'b1;
    addr  <= `UBC_OFS_BDT_TOP;
    wdata <= 32'h0000_003C;
    #1;
    chk(rdata, 32'h5A);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, 32'h3C);
    settle();
    chk(bdt_base, 32'h3C5A_0000);
    // configuration bits against their conditions
    wr_reg(`UBC_OFS_CFG, 32'hFFFF_FFFF);
    rd_chk(`UBC_OFS_CFG, 32'hD1);
    @(posedge clk);
    cpu_idle  <= 1'b1;
    cpu_sleep <= 1'b1;
    u_peer.drive(1'b1);
    settle();
    chk1(eye, 1'b1);
    chk1(oemon, 1'b1);
    chk1(halt, 1'b1);
    chk1(susp, 1'b1);
    u_peer.drive(1'b0);
    settle();
    chk1(oemon, 1'b0);
    u_peer.drive(1'b1);
    wr_reg(`UBC_OFS_CFG, 32'h0);
    settle();
    chk1(eye, 1'b0);
    chk1(oemon, 1'b0);
    chk1(halt, 1'b0);
    chk1(susp, 1'b0);
    @(posedge clk);
    man_susp <= 1'b1;
    settle();
    chk1(susp, 1'b1);
    // enables set but the device neither idle nor asleep
    @(posedge clk);
    man_susp  <= 1'b0;
    cpu_idle  <= 1'b0;
    cpu_sleep <= 1'b0;
    wr_reg(`UBC_OFS_CFG, 32'h0000_0051);
    settle();
    chk1(halt, 1'b0);
    chk1(susp, 1'b0);
    chk1(oemon, 1'b1);
    chk1(eye, 1'b0);
    // implemented bits of every endpoint
    for (int n = 0; n < 16; n++) begin
      wr_reg(ep(n), 32'hFFFF_FFFF);
      rd_chk(ep(n), (n == 0) ? 32'hDF : 32'h1F);
    end
    // host-only endpoint 0 options
    chk1(lsd, 1'b0);
    @(posedge clk);
    host_mode <= 1'b1;
    settle();
    chk1(lsd, 1'b1);
    chk1(retry, 1'b0);
    wr_reg(ep(0), 32'h0);
    settle();
    chk1(lsd, 1'b0);
    chk1(retry, 1'b1);
    @(posedge clk);
    host_mode <= 1'b0;
    settle();
    chk1(retry, 1'b0);
    // live controls of the token endpoint
    u_peer.token(4'h5);
    for (int i = 0; i < 5; i++) begin
      wr_reg(ep(5), {24'h0, tw[i]});
      settle();
      chk({28'h0, tok_ctl}, {28'h0, te[i]});
    end
    u_peer.token(4'h6);
    settle();
    chk({28'h0, tok_ctl}, 32'hD);
    // stall event, sticky bit and interrupt
    wr_reg(ep(3), 32'h0C);
    wr_reg(`UBC_OFS_IRQ_MASK, 32'h1);
    settle();
    chk1(irq, 1'b0);
    u_peer.stall(4'h3);
    settle();
    rd_chk(ep(3), 32'h0E);
    rd_chk(ep(2), 32'h1F);
    rd_chk(`UBC_OFS_IRQ_STAT, 32'h1);
    chk1(irq, 1'b1);
    wr_reg(ep(3), 32'h0C);
    rd_chk(ep(3), 32'h0C);
    wr_reg(`UBC_OFS_IRQ_STAT, 32'h1);
    settle();
    chk1(irq, 1'b0);
    wr_reg(`UBC_OFS_IRQ_MASK, 32'h0);
    u_peer.stall(4'h3);
    settle();
    chk1(irq, 1'b0);
    rd_chk(`UBC_OFS_IRQ_STAT, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
